// *** rtl/ebv_ctrl.sv ***
// external bus visibility control: mode, visibility gating, bus cycles, tester bridge
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ebv_ctrl (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// chip state from the core
	input wire logic secure,
	input wire logic stop_active,
	input wire logic [2:0] mode_strap,
	input wire logic [1:0] core_queue_status,
	// core access port
	input wire logic core_req,
	input wire logic core_ext,
	input wire logic core_write,
	input wire logic core_bdm_sel,
	input wire logic core_noacc,
	input wire logic core_low_byte_strobe_n,
	input wire logic [15:0] core_addr,
	input wire logic [15:0] core_wdata,
	output logic core_ack,
	output logic [15:0] core_rdata,
	// multiplexed address and data pins
	input wire logic [15:0] ad_in,
	output logic [15:0] ad_out,
	output logic [15:0] ad_oe_n,
	// bus control pins
	output logic bus_phase_clock,
	output logic read_write,
	output logic low_byte_strobe_n,
	output logic queue_status_hi,
	output logic queue_status_lo,
	output logic pipe_status_output_enable,
	output logic byte_strobe_output_enable,
	output logic read_write_output_enable,
	// tester side in peripheral test mode
	input wire logic tester_clock,
	input wire logic tester_read_write,
	input wire logic tester_low_byte_strobe_n,
	input wire logic [15:0] tst_rdata,
	output logic tst_req,
	output logic tst_write,
	output logic tst_low_byte_strobe_n,
	output logic [15:0] tst_addr,
	output logic [15:0] tst_wdata
);
	// synchronised pins
	logic [21:0] pins_s; // strap, ad, tester clock, rw, strobe
	logic [2:0] strap_s;
	logic [15:0] ad_s;
	logic tck_s;
	logic trw_s;
	logic tls_s;
	logic tck_d; // previous tester clock sample for edge finding
	// software state
	logic [2:0] mode_select_bits;
	logic visibility_enable_bit;
	logic strap_taken; // strap caught once after reset release
	logic [1:0] strap_wait; // fills with ones after release while the strap crosses the syncs
	// bus sequencer state
	ebv_pkg::bus_state_e state;
	logic [2:0] cnt;
	logic hold_data; // debug unit cycle: data pins keep old value
	logic cyc_write;
	logic [15:0] cyc_wdata;
	logic [15:0] last_data;
	logic drive_rd; // tester read in progress

	ebv_sync #(.WIDTH(22)) u_sync (
		.clock(clock),
		.rst(rst),
		.d({mode_strap, ad_in, tester_clock, tester_read_write, tester_low_byte_strobe_n}),
		.q(pins_s)
	);
	assign strap_s = pins_s[21:19];
	assign ad_s = pins_s[18:3];
	assign tck_s = pins_s[2];
	assign trw_s = pins_s[1];
	assign tls_s = pins_s[0];

	// mode decode
	wire single = ebv_pkg::is_single(mode_select_bits);
	wire periph = (mode_select_bits == ebv_pkg::MODE_PERIPH_TEST);
	wire expanded = ebv_pkg::is_expanded(mode_select_bits);
	// visibility needs the bit, a capable mode and no security
	wire vis_active = visibility_enable_bit & ~secure &
		ebv_pkg::vis_capable(mode_select_bits);

	// apb decode
	wire sel_mode = (paddr == ebv_pkg::OFF_MODE);
	wire sel_ena = (paddr == ebv_pkg::OFF_ENABLE);
	wire sel_stat = (paddr == ebv_pkg::OFF_STATUS);
	wire apb_acc = psel & penable & ~pready;
	wire apb_done = psel & penable & pready;
	// mode register refused in peripheral test mode
	wire apb_err = (sel_mode & periph) | ~(sel_mode | sel_ena | sel_stat);
	wire wr_mode = apb_done & pwrite & sel_mode & ~periph;
	wire wr_ena = apb_done & pwrite & sel_ena;
	// special modes may rewrite the mode, never while secure
	wire mode_wr_ok = ~secure & ~mode_select_bits[2];
	wire [31:0] rd_mode = {28'h0000000, visibility_enable_bit, mode_select_bits};
	wire [31:0] rd_ena = {29'h00000000, read_write_output_enable,
		byte_strobe_output_enable, pipe_status_output_enable};
	wire [31:0] rd_stat = {25'h0000000, stop_active, (state != ebv_pkg::BUS_IDLE),
		secure, vis_active, mode_select_bits};
	wire [31:0] rd_value = apb_err ? 32'h00000000 :
		sel_mode ? rd_mode : sel_ena ? rd_ena : rd_stat;

	// core request classification, taken only from idle
	wire can_take = (state == ebv_pkg::BUS_IDLE) & core_req & ~core_ack & ~stop_active;
	wire take_ext = can_take & expanded & core_ext;
	wire take_vis = can_take & expanded & ~core_ext & vis_active & ~core_noacc &
		~core_bdm_sel;
	wire take_bdm = can_take & expanded & ~core_ext & vis_active & core_bdm_sel;
	wire go_cycle = take_ext | take_vis | take_bdm;
	// hidden, idle or busless accesses finish at once without touching pins
	wire go_quiet = can_take & ~go_cycle;
	wire rise = tck_s & ~tck_d;
	wire fall = ~tck_s & tck_d;

	// apb answer: one wait state, data and error registered together
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= apb_acc;
			prdata <= apb_acc ? rd_value : prdata;
			pslverr <= apb_acc & apb_err;
		end
	end

	// mode and enable registers; the strap is caught after release, not in reset
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode_select_bits <= ebv_pkg::MODE_RST;
			visibility_enable_bit <= ebv_pkg::VIS_RST;
			strap_taken <= 1'b0;
			strap_wait <= 2'h0;
		end
		else if (!strap_taken)
		begin
			// the synchroniser is cleared in reset, so wait until the strap is through it
			strap_wait <= {strap_wait[0], 1'b1};
			if (strap_wait[1])
			begin
				mode_select_bits <= strap_s;
				strap_taken <= 1'b1;
			end
		end
		else if (wr_mode)
		begin
			// secure mode keeps the mode bits as they are
			if (mode_wr_ok)
				mode_select_bits <= pwdata[ebv_pkg::MODE_LSB +: 3];
			visibility_enable_bit <= pwdata[ebv_pkg::VIS_BIT];
		end
	end

	// pin function enables: forced clear in single-chip, so writes there do nothing
	always_ff @(posedge clock)
	begin
		if (rst || single)
		begin
			pipe_status_output_enable <= ebv_pkg::ENA_RST[ebv_pkg::PIPE_BIT];
			byte_strobe_output_enable <= ebv_pkg::ENA_RST[ebv_pkg::STRB_BIT];
			read_write_output_enable <= ebv_pkg::ENA_RST[ebv_pkg::RDW_BIT];
		end
		else if (wr_ena)
		begin
			pipe_status_output_enable <= pwdata[ebv_pkg::PIPE_BIT];
			byte_strobe_output_enable <= pwdata[ebv_pkg::STRB_BIT];
			read_write_output_enable <= pwdata[ebv_pkg::RDW_BIT];
		end
	end

	// queue status: shown only when enabled, zero whenever secure
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			queue_status_hi <= 1'b0;
			queue_status_lo <= 1'b0;
		end
		else
		begin
			queue_status_hi <= pipe_status_output_enable & ~secure &
				core_queue_status[1];
			queue_status_lo <= pipe_status_output_enable & ~secure &
				core_queue_status[0];
		end
	end

	// bus cycle sequencer and pin drivers; all pins hold while stopped
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= ebv_pkg::BUS_IDLE;
			cnt <= 3'h0;
			bus_phase_clock <= 1'b0;
			read_write <= 1'b1;
			low_byte_strobe_n <= 1'b1;
			ad_out <= 16'h0000;
			ad_oe_n <= 16'hFFFF;
			core_ack <= 1'b0;
			core_rdata <= 16'h0000;
			hold_data <= 1'b0;
			cyc_write <= 1'b0;
			cyc_wdata <= 16'h0000;
			last_data <= 16'h0000;
		end
		else if (stop_active)
			core_ack <= 1'b0;
		else
		begin
			core_ack <= 1'b0;
			case (state)
				ebv_pkg::BUS_IDLE:
				begin
					if (go_cycle)
					begin
						// address phase: clock low, address out
						state <= ebv_pkg::BUS_ADDR;
						cnt <= 3'(ebv_pkg::ADDR_CYC - 1);
						ad_out <= core_addr;
						ad_oe_n <= 16'h0000;
						read_write <= ~(core_write & ~take_bdm);
						low_byte_strobe_n <= core_low_byte_strobe_n;
						hold_data <= take_bdm;
						cyc_write <= core_write & ~take_bdm;
						cyc_wdata <= core_wdata;
					end
					else if (go_quiet)
					begin
						// nothing changes on the pins; read/write rests high
						core_ack <= 1'b1;
						read_write <= 1'b1;
					end
					else if (single)
					begin
						// parked low and released to cut switching power
						ad_out <= 16'h0000;
						ad_oe_n <= 16'hFFFF;
					end
					else if (periph)
					begin
						// tester read data driven while its clock is high
						ad_out <= tst_rdata;
						ad_oe_n <= {16{~drive_rd}};
					end
				end
				ebv_pkg::BUS_ADDR:
				begin
					cnt <= cnt - 3'h1;
					if (cnt == 3'h0)
					begin
						// data phase: clock high
						state <= ebv_pkg::BUS_DATA;
						cnt <= 3'(ebv_pkg::DATA_CYC - 1);
						bus_phase_clock <= 1'b1;
						if (hold_data)
							ad_out <= last_data;
						else if (cyc_write)
						begin
							ad_out <= cyc_wdata;
							last_data <= cyc_wdata;
						end
						else
							ad_oe_n <= 16'hFFFF;
					end
				end
				ebv_pkg::BUS_DATA:
				begin
					cnt <= cnt - 3'h1;
					if (cnt == 3'h0)
					begin
						state <= ebv_pkg::BUS_IDLE;
						bus_phase_clock <= 1'b0;
						core_ack <= 1'b1;
						read_write <= 1'b1;
						if (!hold_data && !cyc_write)
						begin
							core_rdata <= ad_s;
							last_data <= ad_s;
						end
					end
				end
				default:
					state <= ebv_pkg::BUS_IDLE;
			endcase
		end
	end

	// tester bridge: edges of the sampled tester clock frame each access;
	// peripheral test mode keeps the debug unit quiet, since both would fight for the bus
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			tck_d <= 1'b0;
			drive_rd <= 1'b0;
			tst_req <= 1'b0;
			tst_write <= 1'b0;
			tst_low_byte_strobe_n <= 1'b1;
			tst_addr <= 16'h0000;
			tst_wdata <= 16'h0000;
		end
		else if (stop_active || !periph)
		begin
			tst_req <= 1'b0;
			drive_rd <= 1'b0;
			tck_d <= tck_s;
		end
		else
		begin
			tck_d <= tck_s;
			tst_req <= 1'b0;
			if (rise)
			begin
				// address and direction taken at the rising edge
				tst_addr <= ad_s;
				tst_write <= ~trw_s;
				tst_low_byte_strobe_n <= tls_s;
				tst_req <= trw_s;
				drive_rd <= trw_s;
			end
			else if (fall)
			begin
				// write data taken at the falling edge
				drive_rd <= 1'b0;
				tst_wdata <= ad_s;
				tst_req <= ~trw_s;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// mode register cannot change by apb in peripheral test mode
	property p_periph_lock;
		apb_done && pwrite && sel_mode && periph && strap_taken |=> $stable(mode_select_bits);
	endproperty
	a_periph_lock: assert property (p_periph_lock) else $error("mode changed in periph test");

	// secure mode write leaves the mode bits alone
	property p_secure_mod;
		wr_mode && secure && strap_taken |=> $stable(mode_select_bits);
	endproperty
	a_secure_mod: assert property (p_secure_mod) else $error("mode written while secure");

	// internal access outside a capable, enabled, non-secure state never starts a bus cycle
	property p_vis_gate;
		(state == ebv_pkg::BUS_IDLE) && !core_ext &&
			!(ebv_pkg::vis_capable(mode_select_bits) && visibility_enable_bit && !secure)
			|=> (state == ebv_pkg::BUS_IDLE);
	endproperty
	a_vis_gate: assert property (p_vis_gate) else $error("visibility in wrong state");

	// hidden internal access: acked next cycle with pins unchanged
	property p_hidden;
		can_take && !core_ext && !vis_active |=>
			core_ack && !bus_phase_clock && read_write && $stable(ad_out) &&
			$stable(low_byte_strobe_n);
	endproperty
	a_hidden: assert property (p_hidden) else $error("hidden cycle disturbed pins");

	// idle cycle with visibility on leaves everything as it was
	property p_noacc;
		can_take && expanded && !core_ext && vis_active && core_noacc && !core_bdm_sel |=>
			core_ack && read_write && $stable(ad_out) && $stable(ad_oe_n);
	endproperty
	a_noacc: assert property (p_noacc) else $error("idle cycle disturbed pins");

	// debug cycle: read/write high throughout and ack after the full cycle
	sequence s_bdm_body;
		read_write [*5] ##1 core_ack;
	endsequence
	property p_bdm;
		disable iff (rst || stop_active) take_bdm |=> s_bdm_body;
	endproperty
	a_bdm: assert property (p_bdm) else $error("debug cycle drove read/write low");

	// visible cycle: two low then three high phase-clock cycles, then ack
	sequence s_addr_phase;
		(!bus_phase_clock && !ad_oe_n[0]) [*2];
	endsequence
	sequence s_data_phase;
		bus_phase_clock [*3] ##1 (!bus_phase_clock && core_ack);
	endsequence
	property p_visible;
		disable iff (rst || stop_active) take_vis |=> s_addr_phase ##1 s_data_phase;
	endproperty
	a_visible: assert property (p_visible) else $error("visible cycle timing wrong");

	// queue status shows zero whenever secure
	property p_queue;
		secure |=> !queue_status_hi && !queue_status_lo;
	endproperty
	a_queue: assert property (p_queue) else $error("queue status visible while secure");

	// single-chip: pipe status and read/write enables clear, address pins parked
	property p_single;
		single && $past(single) && strap_taken |=> !pipe_status_output_enable &&
			!read_write_output_enable && (ad_oe_n == 16'hFFFF);
	endproperty
	a_single: assert property (p_single) else $error("single-chip pins not parked");

	// stop freezes the sequencer and the pins
	property p_stop;
		stop_active |=> $stable(state) && $stable(ad_out) && $stable(bus_phase_clock);
	endproperty
	a_stop: assert property (p_stop) else $error("bus moved while stopped");
endmodule // ebv_ctrl

// *** rtl/ebv_pkg.sv ***
// shared constants, types and decode functions of the external bus visibility control
package ebv_pkg;
	// clock and bus phase timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int ADDR_PHASE_NS = 10;
	// three data cycles: read data released at the phase edge must cross the pin synchroniser
	localparam int DATA_PHASE_NS = 15;
	// least times round up to whole clock cycles
	localparam int ADDR_CYC = (ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_CYC = (DATA_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// operating mode codes held in mode_select_bits
	localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
	localparam logic [2:0] MODE_EMUL_NARROW = 3'h1;
	localparam logic [2:0] MODE_SPECIAL_TEST = 3'h2;
	localparam logic [2:0] MODE_EMUL_WIDE = 3'h3;
	localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
	localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
	localparam logic [2:0] MODE_PERIPH_TEST = 3'h6;
	localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;
	// register byte offsets on the apb
	localparam logic [11:0] OFF_MODE = 12'h000;
	localparam logic [11:0] OFF_ENABLE = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	// field positions
	localparam int MODE_LSB = 0;
	localparam int VIS_BIT = 3;
	localparam int PIPE_BIT = 0;
	localparam int STRB_BIT = 1;
	localparam int RDW_BIT = 2;
	localparam int ST_VIS = 3;
	localparam int ST_SECURE = 4;
	localparam int ST_BUSY = 5;
	localparam int ST_STOP = 6;
	// values after reset
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic VIS_RST = 1'b0;
	localparam logic [2:0] ENA_RST = 3'h0;
	// bus cycle sequencer states
	typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA} bus_state_e;
	// single-chip modes have no expansion bus
	function automatic logic is_single(input logic [2:0] m);
		return (m == MODE_SPECIAL_SINGLE) || (m == MODE_NORMAL_SINGLE);
	endfunction
	// modes that may show internal cycles
	function automatic logic vis_capable(input logic [2:0] m);
		return (m == MODE_EMUL_NARROW) || (m == MODE_SPECIAL_TEST) ||
			(m == MODE_EMUL_WIDE) || (m == MODE_NORMAL_WIDE);
	endfunction
	// modes in which this block masters the expansion bus
	function automatic logic is_expanded(input logic [2:0] m);
		return !is_single(m) && (m != MODE_PERIPH_TEST);
	endfunction
endpackage

// *** rtl/ebv_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebv_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// asynchronous input and its synchronised copy
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1; // read only by the second stage
	// metastability filter; the first stage feeds nothing else
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			stage1 <= '0;
			q <= '0;
		end
		else
		begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule // ebv_sync

// *** sim/ext_partner.sv ***
// far side model: external memory on the multiplexed bus and a tester bus master
`timescale 1ns/1ps
module ext_partner #(
	parameter logic [15:0] RD_WORD = 16'hC3A5
) (
	// pins driven by the device
	input wire logic [15:0] ad_out,
	input wire logic [15:0] ad_oe_n,
	input wire logic read_write,
	// pins seen by the device
	output logic [15:0] ad_in,
	output logic tester_clock,
	output logic tester_read_write,
	output logic tester_low_byte_strobe_n
);
	logic tester_active; // tester owns the pins
	logic [15:0] tester_bus; // value driven by the tester
	logic [15:0] seen_data; // device data caught while tester clock is high
	wire logic [15:0] far_drive;
	// memory answers reads; an undriven bus shows the inverse so a stale value never passes
	assign far_drive = tester_active ? tester_bus : (read_write ? RD_WORD : ~ad_out);
	// wire level from the device's enables; the far side drives every bit the device releases
	assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & far_drive);
	// idle pins; the link clock stands still between frames
	initial
	begin
		tester_active = 1'b0;
		tester_bus = 16'h0000;
		tester_clock = 1'b0;
		tester_read_write = 1'b1;
		tester_low_byte_strobe_n = 1'b1;
		seen_data = 16'h0000;
	end
	// one tester frame of 160 ns or more; the tester never calls on debug
	task tester_cycle(input logic wr, input logic [15:0] a, input logic [15:0] d);
		// step off the device clock edge so no pin moves as it is sampled
		#1;
		tester_active = 1'b1;
		tester_bus = a;
		tester_read_write = !wr;
		tester_low_byte_strobe_n = 1'b0;
		#10;
		tester_clock = 1'b1;
		// address held 40 ns; a read then hands the pins to the device
		#40;
		tester_active = wr;
		tester_bus = d;
		#30;
		seen_data = ad_out;
		#10;
		tester_clock = 1'b0;
		#40;
		tester_active = 1'b0;
		tester_read_write = 1'b1;
		#30;
	endtask
endmodule // ext_partner

// *** sim/testbench.sv ***
// self-checking testbench of the external bus visibility control
`timescale 1ns/1ps
module testbench;
	// apb and chip state
	logic clock, rst, psel, penable, pwrite, pready, pslverr, secure, stop_active;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] mode_strap;
	logic [1:0] core_queue_status;
	// core port
	logic core_req, core_ext, core_write, core_bdm_sel, core_noacc, core_low_byte_strobe_n;
	logic core_ack;
	logic [15:0] core_addr, core_wdata, core_rdata, prev;
	// pins
	logic [15:0] ad_in, ad_out, ad_oe_n, tst_addr, tst_wdata;
	logic bus_phase_clock, read_write, queue_status_hi, queue_status_lo, tst_req, tst_write;
	logic tester_clock, tester_read_write, tester_low_byte_strobe_n;
	// bench state
	logic er, ph, rwl, hit, chg;
	int fail_count, checked, treq, k;
	ebv_ctrl u_ebv_ctrl (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .secure, .stop_active, .mode_strap, .core_queue_status, .core_req,
		.core_ext, .core_write, .core_bdm_sel, .core_noacc, .core_low_byte_strobe_n,
		.core_addr, .core_wdata, .core_ack, .core_rdata, .ad_in, .ad_out, .ad_oe_n,
		.bus_phase_clock, .read_write, .low_byte_strobe_n(), .queue_status_hi,
		.queue_status_lo, .pipe_status_output_enable(), .byte_strobe_output_enable(),
		.read_write_output_enable(), .tester_clock, .tester_read_write,
		.tester_low_byte_strobe_n, .tst_rdata(16'h5A3C), .tst_req, .tst_write,
		.tst_low_byte_strobe_n(), .tst_addr, .tst_wdata);
	ext_partner u_ext_partner (.ad_out, .ad_oe_n, .read_write, .ad_in, .tester_clock,
		.tester_read_write, .tester_low_byte_strobe_n);
	// 200 MHz clock
	always #2.5 clock = ~clock;
	// count bridge requests from the tester
	always @(posedge clock)
		if (tst_req === 1'b1)
			treq <= treq + 1;
	// verdict and end of run
	task conclude;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one comparison
	task chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			fail_count++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	// a wait that ran out ends the run
	task lost(input string m);
		chk(1'b0, m);
		conclude;
	endtask
	// reset with a given mode on the strap pins
	task restart(input logic [2:0] m);
		@(posedge clock);
		rst <= 1'b1;
		mode_strap <= m;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	// apb transfer: setup, access, hold until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20)
			lost("apb timeout");
	endtask
	// wait for core_ack while watching the pins
	task wait_ack;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
			ph = ph | bus_phase_clock;
			rwl = rwl | !read_write;
			hit = hit | (ad_out === core_addr && ad_oe_n === 16'h0000);
			chg = chg | (ad_out !== prev);
		end
		while (core_ack !== 1'b1 && k < 40);
		if (k >= 40)
			lost("core ack timeout");
	endtask
	// one core access, request held until ack
	task core(input logic e, w, b, n, input logic [15:0] a, d);
		@(posedge clock);
		{core_req, core_ext, core_write, core_bdm_sel, core_noacc} <= {1'b1, e, w, b, n};
		core_addr <= a;
		core_wdata <= d;
		{ph, rwl, hit, chg} = 4'h0;
		prev = ad_out;
		wait_ack;
		core_req <= 1'b0;
	endtask
	// main sequence
	initial
	begin
		{clock, psel, penable, pwrite, secure, stop_active, core_req, core_ext} = 8'h00;
		{core_write, core_bdm_sel, core_noacc, core_low_byte_strobe_n} = 4'h0;
		{paddr, pwdata, core_addr, core_wdata} = 0;
		rst = 1'b1;
		mode_strap = ebv_pkg::MODE_EMUL_WIDE;
		core_queue_status = 2'h3;
		{fail_count, checked, treq} = 0;
		restart(ebv_pkg::MODE_EMUL_WIDE);
		apb(1'b0, ebv_pkg::OFF_STATUS, 32'h0);
		chk(rd[ebv_pkg::ST_VIS] === 1'b0 && rd[2:0] === 3'h3, "status after reset");
		core(1'b0, 1'b0, 1'b0, 1'b0, 16'h1234, 16'h0);
		chk(ph === 1'b0 && rwl === 1'b0 && chg === 1'b0, "hidden cycle shown");
		apb(1'b1, ebv_pkg::OFF_MODE, 32'h0000000B);
		apb(1'b0, ebv_pkg::OFF_STATUS, 32'h0);
		chk(rd[ebv_pkg::ST_VIS] === 1'b1, "visibility off");
		core(1'b0, 1'b1, 1'b0, 1'b0, 16'h2468, 16'h55AA);
		chk(ph === 1'b1 && rwl === 1'b1 && hit === 1'b1, "visible write missing");
		core(1'b0, 1'b0, 1'b1, 1'b0, 16'hBEEF, 16'h0);
		chk(rwl === 1'b0 && hit === 1'b1, "debug cycle");
		core(1'b0, 1'b0, 1'b0, 1'b1, 16'h0F0F, 16'h0);
		chk(rwl === 1'b0 && chg === 1'b0, "idle cycle moved bus");
		core(1'b1, 1'b0, 1'b0, 1'b0, 16'h8000, 16'h0);
		chk(core_rdata === 16'hC3A5 && ph === 1'b1, "external read");
		apb(1'b1, ebv_pkg::OFF_ENABLE, 32'h7);
		apb(1'b0, 12'h0FC, 32'h0);
		chk(er === 1'b1, "unmapped address accepted");
		secure <= 1'b1;
		apb(1'b0, ebv_pkg::OFF_STATUS, 32'h0);
		chk(rd[ebv_pkg::ST_VIS] === 1'b0, "secure visibility");
		chk(queue_status_hi === 1'b0 && queue_status_lo === 1'b0, "queue status shown");
		core(1'b0, 1'b0, 1'b0, 1'b0, 16'h1357, 16'h0);
		chk(ph === 1'b0, "secure cycle shown");
		apb(1'b1, ebv_pkg::OFF_MODE, 32'h9);
		apb(1'b0, ebv_pkg::OFF_MODE, 32'h0);
		chk(rd[2:0] === ebv_pkg::MODE_EMUL_WIDE, "secure mode write");
		secure <= 1'b0;
		stop_active <= 1'b1;
		core_req <= 1'b1;
		k = 0;
		repeat (30)
		begin
			@(posedge clock);
			if (core_ack === 1'b1)
				k++;
		end
		chk(k == 0, "ack during stop");
		stop_active <= 1'b0;
		wait_ack;
		core_req <= 1'b0;
		restart(ebv_pkg::MODE_NORMAL_SINGLE);
		apb(1'b1, ebv_pkg::OFF_ENABLE, 32'h7);
		apb(1'b0, ebv_pkg::OFF_ENABLE, 32'h0);
		chk(rd[2:0] === 3'h0, "single chip enables");
		chk(ad_oe_n === 16'hFFFF, "address pins driven");
		apb(1'b1, ebv_pkg::OFF_MODE, 32'h8);
		core(1'b0, 1'b0, 1'b0, 1'b0, 16'h2222, 16'h0);
		chk(ph === 1'b0, "single chip cycle shown");
		restart(ebv_pkg::MODE_NORMAL_NARROW);
		apb(1'b1, ebv_pkg::OFF_MODE, 32'hD);
		core(1'b0, 1'b0, 1'b0, 1'b0, 16'h3333, 16'h0);
		chk(ph === 1'b0, "narrow cycle shown");
		restart(ebv_pkg::MODE_PERIPH_TEST);
		apb(1'b0, ebv_pkg::OFF_MODE, 32'h0);
		chk(er === 1'b1 && rd === 32'h0, "mode register reachable");
		treq = 0;
		u_ext_partner.tester_cycle(1'b0, 16'h4321, 16'h0);
		chk(tst_addr === 16'h4321 && treq > 0, "tester address");
		chk(u_ext_partner.seen_data === 16'h5A3C, "tester read data");
		u_ext_partner.tester_cycle(1'b1, 16'h1111, 16'hA55A);
		chk(tst_write === 1'b1 && tst_wdata === 16'hA55A && tst_addr === 16'h1111, "tester write");
		conclude;
	end
endmodule // testbench
